// ==== hdl/gpt_pkg.sv ====
// Constants and types shared by the general-purpose timer.
// Summary of operation
// - Config value 0 joins halves into one 32-bit timer, mode from first half.
// - Mode field 1 is one-shot, 2 is periodic.
// - Setting enable starts the counter from its interval value, or from zero in RTC mode.
// - Every timeout, match or capture sets a raw flag; mask gates interrupt.
// - Writing 1 to a clear bit drops raw and masked flag; 0 does nothing.
// - One-shot stops after timeout; periodic keeps counting.
// - Config value 1 selects RTC counting against the first match value.
// - RTC count equal to match reloads zero and keeps counting up.
// - RTC counting continues without software clearing the match flag.
// - Config value 4 splits the module into two independent 16-bit timers.
// - In 16-bit one-shot/periodic a prescale value extends the count range.
// - Capture bit 0 with mode 3 counts input edges of the selected kind.
// - Edge counting stops at the programmed count until re-enabled.
// - Capture bit 1 with mode 3 times edges and raises a maskable flag.
// - In edge timing the count at the edge is read from the count register.
// - Edge timing keeps running; an interval write applies the next cycle.
// - PWM mode needs alternate select 1, capture bit 0 and mode 2; the code does not check the capture bit.
// - A control bit inverts the PWM output.
// - In PWM the prescale extends period and prescale match extends compare.
// - PWM runs continuously; an interval write applies the next cycle.
// - PWM asserts at interval value, drops at match; no status raised.
// - Each edge decrements; at match reload interval and clear enable.
// - In 16-bit one-shot/periodic, reaching zero reloads interval and prescale and, with the trigger enable set, pulses a trigger.
package gpt_pkg;
   localparam int         GPT_AW        = 12;
   localparam logic [11:0] GPT_CFG_OFS   = 12'h000;
   localparam logic [11:0] GPT_AMR_OFS   = 12'h004;
   localparam logic [11:0] GPT_BMR_OFS   = 12'h008;
   localparam logic [11:0] GPT_CTL_OFS   = 12'h00c;
   localparam logic [11:0] GPT_IMR_OFS   = 12'h018;
   localparam logic [11:0] GPT_RIS_OFS   = 12'h01c;
   localparam logic [11:0] GPT_MIS_OFS   = 12'h020;
   localparam logic [11:0] GPT_ICR_OFS   = 12'h024;
   localparam logic [11:0] GPT_AILR_OFS  = 12'h028;
   localparam logic [11:0] GPT_BILR_OFS  = 12'h02c;
   localparam logic [11:0] GPT_AMAT_OFS  = 12'h030;
   localparam logic [11:0] GPT_BMAT_OFS  = 12'h034;
   localparam logic [11:0] GPT_APR_OFS   = 12'h038;
   localparam logic [11:0] GPT_BPR_OFS   = 12'h03c;
   localparam logic [11:0] GPT_APMR_OFS  = 12'h040;
   localparam logic [11:0] GPT_BPMR_OFS  = 12'h044;
   localparam logic [11:0] GPT_ACNT_OFS  = 12'h048;
   localparam logic [11:0] GPT_BCNT_OFS  = 12'h04c;
   localparam logic [2:0]  GPT_CFG_JOIN  = 3'h0;
   localparam logic [2:0]  GPT_CFG_RTC   = 3'h1;
   localparam int          GPT_CFG_SPLIT = 2;
   localparam logic [1:0]  GPT_MR_ONE    = 2'h1;
   localparam logic [1:0]  GPT_MR_PER    = 2'h2;
   localparam logic [1:0]  GPT_MR_CAP    = 2'h3;
   localparam int          GPT_MD_CMR    = 2;
   localparam int          GPT_MD_AMS    = 3;
   localparam logic [1:0]  GPT_EV_RISE   = 2'h0;
   localparam logic [1:0]  GPT_EV_FALL   = 2'h1;
   localparam int          GPT_C_AEN     = 0;
   localparam int          GPT_C_AEV     = 2;
   localparam int          GPT_C_RTC     = 4;
   localparam int          GPT_C_AOTE    = 5;
   localparam int          GPT_C_APWML   = 6;
   localparam int          GPT_C_BEN     = 8;
   localparam int          GPT_C_BEV     = 10;
   localparam int          GPT_C_BOTE    = 13;
   localparam int          GPT_C_BPWML   = 14;
   localparam logic [14:0] GPT_CTL_MASK  = 15'h6d7d;
   localparam int          GPT_I_ATO     = 0;
   localparam int          GPT_I_ACM     = 1;
   localparam int          GPT_I_ACE     = 2;
   localparam int          GPT_I_RTC     = 3;
   localparam int          GPT_I_BTO     = 8;
   localparam int          GPT_I_BCM     = 9;
   localparam int          GPT_I_BCE     = 10;
   localparam logic [10:0] GPT_INT_MASK  = 11'h70f;
   localparam logic [31:0] GPT_A_RST     = 32'hffff_ffff;
   localparam logic [15:0] GPT_B_RST     = 16'hffff;

   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0]  pre;
      logic [15:0] cap;
      logic        pwm;
      logic        en;
      logic        to;
      logic        cm;
      logic        ce;
   } gpt_half_t;
endpackage : gpt_pkg

// ==== hdl/gpt_timer.sv ====
// General-purpose timer with two halves, joined, RTC or split, behind APB.
`timescale 1ns/1ps
module gpt_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ccp_a_in,
   input  wire logic        ccp_b_in,
   output logic             pwm_a,
   output logic             pwm_b,
   output logic             trig_a,
   output logic             trig_b,
   output logic             irq
);
   typedef struct packed {
      logic [2:0]  cfg;
      logic [3:0]  mode_a;
      logic [3:0]  mode_b;
      logic [14:0] ctl;
      logic [10:0] imr;
      logic [10:0] ris;
      logic [31:0] ilr_a;
      logic [31:0] mat_a;
      logic [15:0] ilr_b;
      logic [15:0] mat_b;
      logic [7:0]  pr_a;
      logic [7:0]  pr_b;
      logic [7:0]  pmr_a;
      logic [7:0]  pmr_b;
      logic [31:0] cnt_a;
      logic [15:0] cnt_b;
      logic [7:0]  pre_a;
      logic [7:0]  pre_b;
      logic [15:0] cap_a;
      logic [15:0] cap_b;
      logic        raw_a;
      logic        raw_b;
      logic [2:0]  sync_a;
      logic [2:0]  sync_b;
      logic        lvl_a;
      logic        lvl_b;
      logic        pwm_a;
      logic        pwm_b;
      logic        trig_a;
      logic        trig_b;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } gpt_state_t;

   gpt_state_t        s_q;
   gpt_state_t        s_d;
   gpt_pkg::gpt_half_t ha;
   gpt_pkg::gpt_half_t hb;
   logic              rise_a;
   logic              fall_a;
   logic              rise_b;
   logic              fall_b;
   logic [10:0]       set_v;
   logic              wr;
   logic              acc;
   logic              split;

   function automatic logic edge_sel(input logic [1:0] ev, input logic r, input logic f);
      if (ev == gpt_pkg::GPT_EV_RISE) begin
         return r;
      end else if (ev == gpt_pkg::GPT_EV_FALL) begin
         return f;
      end
      return r | f;
   endfunction : edge_sel

   // One step of a 16-bit half; the prescaler forms the upper 8 bits of a 24-bit count.
   function automatic gpt_pkg::gpt_half_t half_step(input logic [3:0] md, input logic [1:0] ev,
         input logic [15:0] ilr, input logic [15:0] mat, input logic [7:0] pr,
         input logic [7:0] pmr, input gpt_pkg::gpt_half_t cur, input logic r, input logic f);
      gpt_pkg::gpt_half_t n;
      logic [23:0]        v;
      logic               hit;
      n = cur;
      n.to = 1'b0;
      n.cm = 1'b0;
      n.ce = 1'b0;
      v = {cur.pre, cur.cnt};
      hit = edge_sel(ev, r, f);
      if (cur.en && md[1:0] == gpt_pkg::GPT_MR_CAP) begin
         if (!md[gpt_pkg::GPT_MD_CMR]) begin
            if (hit) begin
               if (cur.cnt - 16'h1 == mat) begin
                  n.cnt = ilr;
                  n.cm = 1'b1;
                  n.en = 1'b0;
               end else begin
                  n.cnt = cur.cnt - 16'h1;
               end
            end
         end else begin
            n.cnt = (cur.cnt == 16'h0) ? ilr : cur.cnt - 16'h1;
            if (hit) begin
               n.cap = cur.cnt;
               n.ce = 1'b1;
            end
         end
      end else if (cur.en && md[1:0] != 2'h0) begin
         if (v == 24'h0) begin
            n.cnt = ilr;
            n.pre = pr;
            if (md[gpt_pkg::GPT_MD_AMS] && md[1:0] == gpt_pkg::GPT_MR_PER) begin
               n.pwm = 1'b1;
            end else begin
               n.to = 1'b1;
               n.en = (md[1:0] != gpt_pkg::GPT_MR_ONE);
            end
         end else begin
            {n.pre, n.cnt} = v - 24'h1;
            if (md[gpt_pkg::GPT_MD_AMS] && {n.pre, n.cnt} == {pmr, mat}) begin
               n.pwm = 1'b0;
            end
         end
      end
      return n;
   endfunction : half_step

   function automatic logic mapped(input logic [11:0] a);
      case (a)
         gpt_pkg::GPT_CFG_OFS, gpt_pkg::GPT_AMR_OFS, gpt_pkg::GPT_BMR_OFS, gpt_pkg::GPT_CTL_OFS,
         gpt_pkg::GPT_IMR_OFS, gpt_pkg::GPT_RIS_OFS, gpt_pkg::GPT_MIS_OFS, gpt_pkg::GPT_ICR_OFS,
         gpt_pkg::GPT_AILR_OFS, gpt_pkg::GPT_BILR_OFS, gpt_pkg::GPT_AMAT_OFS, gpt_pkg::GPT_BMAT_OFS,
         gpt_pkg::GPT_APR_OFS, gpt_pkg::GPT_BPR_OFS, gpt_pkg::GPT_APMR_OFS, gpt_pkg::GPT_BPMR_OFS,
         gpt_pkg::GPT_ACNT_OFS, gpt_pkg::GPT_BCNT_OFS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : mapped

   // Edges count only once the second and third stages agree, so a bounce gives one event.
   assign rise_a = s_q.sync_a[1] & s_q.sync_a[2] & ~s_q.lvl_a;
   assign fall_a = ~s_q.sync_a[1] & ~s_q.sync_a[2] & s_q.lvl_a;
   assign rise_b = s_q.sync_b[1] & s_q.sync_b[2] & ~s_q.lvl_b;
   assign fall_b = ~s_q.sync_b[1] & ~s_q.sync_b[2] & s_q.lvl_b;
   assign split = s_q.cfg[gpt_pkg::GPT_CFG_SPLIT];
   assign acc = psel & penable & ~s_q.pready;
   assign wr = psel & penable & pwrite & s_q.pready;

   assign ha = half_step(s_q.mode_a, s_q.ctl[gpt_pkg::GPT_C_AEV +: 2], s_q.ilr_a[15:0],
      s_q.mat_a[15:0], s_q.pr_a, s_q.pmr_a,
      {s_q.cnt_a[15:0], s_q.pre_a, s_q.cap_a, s_q.raw_a, s_q.ctl[gpt_pkg::GPT_C_AEN], 3'h0},
      rise_a, fall_a);
   assign hb = half_step(s_q.mode_b, s_q.ctl[gpt_pkg::GPT_C_BEV +: 2], s_q.ilr_b, s_q.mat_b,
      s_q.pr_b, s_q.pmr_b,
      {s_q.cnt_b, s_q.pre_b, s_q.cap_b, s_q.raw_b, s_q.ctl[gpt_pkg::GPT_C_BEN], 3'h0},
      rise_b, fall_b);

   always_comb begin
      logic        ld_a;
      logic        ld_b;
      logic        j_to;
      logic        rtc_hit;
      logic [31:0] rd;
      ld_a = 1'b0;
      ld_b = 1'b0;
      j_to = 1'b0;
      rtc_hit = 1'b0;
      rd = 32'h0;
      s_d = s_q;
      s_d.sync_a = {s_q.sync_a[1:0], ccp_a_in};
      s_d.sync_b = {s_q.sync_b[1:0], ccp_b_in};
      if (s_q.sync_a[1] == s_q.sync_a[2]) begin
         s_d.lvl_a = s_q.sync_a[2];
      end
      if (s_q.sync_b[1] == s_q.sync_b[2]) begin
         s_d.lvl_b = s_q.sync_b[2];
      end

      if (split) begin
         s_d.cnt_a = {16'h0, ha.cnt};
         s_d.pre_a = ha.pre;
         s_d.cap_a = ha.cap;
         s_d.raw_a = ha.pwm;
         s_d.ctl[gpt_pkg::GPT_C_AEN] = ha.en;
         s_d.cnt_b = hb.cnt;
         s_d.pre_b = hb.pre;
         s_d.cap_b = hb.cap;
         s_d.raw_b = hb.pwm;
         s_d.ctl[gpt_pkg::GPT_C_BEN] = hb.en;
      end else if (s_q.cfg == gpt_pkg::GPT_CFG_JOIN) begin
         if (s_q.ctl[gpt_pkg::GPT_C_AEN] && (s_q.mode_a[1:0] == gpt_pkg::GPT_MR_ONE ||
               s_q.mode_a[1:0] == gpt_pkg::GPT_MR_PER)) begin
            if (s_q.cnt_a == 32'h0) begin
               s_d.cnt_a = s_q.ilr_a;
               j_to = 1'b1;
               s_d.ctl[gpt_pkg::GPT_C_AEN] = (s_q.mode_a[1:0] == gpt_pkg::GPT_MR_PER);
            end else begin
               s_d.cnt_a = s_q.cnt_a - 32'h1;
            end
         end
      end else if (s_q.cfg == gpt_pkg::GPT_CFG_RTC) begin
         // The flag is never consulted here, so counting goes on while it stays set.
         if (s_q.ctl[gpt_pkg::GPT_C_AEN] && s_q.ctl[gpt_pkg::GPT_C_RTC] && rise_a) begin
            if (s_q.cnt_a == s_q.mat_a) begin
               s_d.cnt_a = 32'h0;
               rtc_hit = 1'b1;
            end else begin
               s_d.cnt_a = s_q.cnt_a + 32'h1;
            end
         end
      end

      s_d.pready = acc;
      s_d.pslverr = acc & ~mapped(paddr);
      if (wr) begin
         unique case (paddr)
            gpt_pkg::GPT_CFG_OFS:  s_d.cfg = pwdata[2:0];
            gpt_pkg::GPT_AMR_OFS:  s_d.mode_a = pwdata[3:0];
            gpt_pkg::GPT_BMR_OFS:  s_d.mode_b = pwdata[3:0];
            gpt_pkg::GPT_CTL_OFS: begin
               s_d.ctl = pwdata[14:0] & gpt_pkg::GPT_CTL_MASK;
               ld_a = pwdata[gpt_pkg::GPT_C_AEN] & ~s_q.ctl[gpt_pkg::GPT_C_AEN];
               ld_b = pwdata[gpt_pkg::GPT_C_BEN] & ~s_q.ctl[gpt_pkg::GPT_C_BEN];
            end
            gpt_pkg::GPT_IMR_OFS:  s_d.imr = pwdata[10:0] & gpt_pkg::GPT_INT_MASK;
            gpt_pkg::GPT_AILR_OFS: begin
               s_d.ilr_a = pwdata;
               s_d.cnt_a = split ? {16'h0, pwdata[15:0]} : pwdata;
            end
            gpt_pkg::GPT_BILR_OFS: begin
               s_d.ilr_b = pwdata[15:0];
               s_d.cnt_b = pwdata[15:0];
            end
            gpt_pkg::GPT_AMAT_OFS: s_d.mat_a = pwdata;
            gpt_pkg::GPT_BMAT_OFS: s_d.mat_b = pwdata[15:0];
            gpt_pkg::GPT_APR_OFS:  s_d.pr_a = pwdata[7:0];
            gpt_pkg::GPT_BPR_OFS:  s_d.pr_b = pwdata[7:0];
            gpt_pkg::GPT_APMR_OFS: s_d.pmr_a = pwdata[7:0];
            gpt_pkg::GPT_BPMR_OFS: s_d.pmr_b = pwdata[7:0];
            default: ;
         endcase
      end
      if (ld_a) begin
         s_d.cnt_a = (s_q.cfg == gpt_pkg::GPT_CFG_RTC) ? 32'h0 :
                     split ? {16'h0, s_q.ilr_a[15:0]} : s_q.ilr_a;
         s_d.pre_a = s_q.pr_a;
         s_d.raw_a = 1'b1;
      end
      if (ld_b) begin
         s_d.cnt_b = s_q.ilr_b;
         s_d.pre_b = s_q.pr_b;
         s_d.raw_b = 1'b1;
      end

      // A hardware event in the same cycle as its clear write wins over the clear.
      s_d.ris = s_q.ris & ~((wr && paddr == gpt_pkg::GPT_ICR_OFS) ? pwdata[10:0] : 11'h0);
      s_d.ris = s_d.ris | set_v;
      s_d.irq = |(s_d.ris & s_d.imr);
      s_d.trig_a = (split ? ha.to : j_to) & s_q.ctl[gpt_pkg::GPT_C_AOTE];
      s_d.trig_b = split & hb.to & s_q.ctl[gpt_pkg::GPT_C_BOTE];
      s_d.pwm_a = s_d.raw_a ^ s_d.ctl[gpt_pkg::GPT_C_APWML];
      s_d.pwm_b = s_d.raw_b ^ s_d.ctl[gpt_pkg::GPT_C_BPWML];

      unique case (paddr)
         gpt_pkg::GPT_CFG_OFS:  rd = {29'h0, s_q.cfg};
         gpt_pkg::GPT_AMR_OFS:  rd = {28'h0, s_q.mode_a};
         gpt_pkg::GPT_BMR_OFS:  rd = {28'h0, s_q.mode_b};
         gpt_pkg::GPT_CTL_OFS:  rd = {17'h0, s_q.ctl};
         gpt_pkg::GPT_IMR_OFS:  rd = {21'h0, s_q.imr};
         gpt_pkg::GPT_RIS_OFS:  rd = {21'h0, s_q.ris};
         gpt_pkg::GPT_MIS_OFS:  rd = {21'h0, s_q.ris & s_q.imr};
         gpt_pkg::GPT_AILR_OFS: rd = s_q.ilr_a;
         gpt_pkg::GPT_BILR_OFS: rd = {16'h0, s_q.ilr_b};
         gpt_pkg::GPT_AMAT_OFS: rd = s_q.mat_a;
         gpt_pkg::GPT_BMAT_OFS: rd = {16'h0, s_q.mat_b};
         gpt_pkg::GPT_APR_OFS:  rd = {24'h0, s_q.pr_a};
         gpt_pkg::GPT_BPR_OFS:  rd = {24'h0, s_q.pr_b};
         gpt_pkg::GPT_APMR_OFS: rd = {24'h0, s_q.pmr_a};
         gpt_pkg::GPT_BPMR_OFS: rd = {24'h0, s_q.pmr_b};
         gpt_pkg::GPT_ACNT_OFS: rd = (split && s_q.mode_a[gpt_pkg::GPT_MD_CMR]) ?
                                     {16'h0, s_q.cap_a} : s_q.cnt_a;
         gpt_pkg::GPT_BCNT_OFS: rd = {16'h0, s_q.mode_b[gpt_pkg::GPT_MD_CMR] ? s_q.cap_b : s_q.cnt_b};
         default:               rd = 32'h0;
      endcase
      s_d.prdata = (acc && !pwrite) ? rd : 32'h0;
   end

   always_comb begin
      set_v = 11'h0;
      set_v[gpt_pkg::GPT_I_ATO] = split ? ha.to : (s_q.cfg == gpt_pkg::GPT_CFG_JOIN &&
         s_q.ctl[gpt_pkg::GPT_C_AEN] && s_q.cnt_a == 32'h0 && s_q.mode_a[1:0] != 2'h0 &&
         s_q.mode_a[1:0] != gpt_pkg::GPT_MR_CAP);
      set_v[gpt_pkg::GPT_I_ACM] = split & ha.cm;
      set_v[gpt_pkg::GPT_I_ACE] = split & ha.ce;
      set_v[gpt_pkg::GPT_I_RTC] = s_q.cfg == gpt_pkg::GPT_CFG_RTC && s_q.ctl[gpt_pkg::GPT_C_AEN] &&
         s_q.ctl[gpt_pkg::GPT_C_RTC] && rise_a && s_q.cnt_a == s_q.mat_a;
      set_v[gpt_pkg::GPT_I_BTO] = split & hb.to;
      set_v[gpt_pkg::GPT_I_BCM] = split & hb.cm;
      set_v[gpt_pkg::GPT_I_BCE] = split & hb.ce;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ilr_a <= gpt_pkg::GPT_A_RST;
         s_q.mat_a <= gpt_pkg::GPT_A_RST;
         s_q.cnt_a <= gpt_pkg::GPT_A_RST;
         s_q.ilr_b <= gpt_pkg::GPT_B_RST;
         s_q.mat_b <= gpt_pkg::GPT_B_RST;
         s_q.cnt_b <= gpt_pkg::GPT_B_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pwm_a = s_q.pwm_a;
   assign pwm_b = s_q.pwm_b;
   assign trig_a = s_q.trig_a;
   assign trig_b = s_q.trig_b;
   assign irq = s_q.irq;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   a_apb_answer: assert property (s_access |=> s_answer) else $error("APB answer not one wait state");
   a_irq_masked: assert property (irq == |(s_q.ris & s_q.imr))
      else $error("irq does not match masked flags");
   a_clear_bit: assert property (wr && paddr == gpt_pkg::GPT_ICR_OFS && pwdata[gpt_pkg::GPT_I_BTO]
      && !set_v[gpt_pkg::GPT_I_BTO] |=> !s_q.ris[gpt_pkg::GPT_I_BTO])
      else $error("clear write left flag set");
   a_oneshot_stop: assert property (split && hb.to && s_q.mode_b[1:0] == gpt_pkg::GPT_MR_ONE && !wr
      |=> !s_q.ctl[gpt_pkg::GPT_C_BEN] && s_q.ris[gpt_pkg::GPT_I_BTO])
      else $error("one-shot did not stop");
   a_rtc_wrap: assert property (set_v[gpt_pkg::GPT_I_RTC] && !wr |=> s_q.cnt_a == 32'h0 ##1
      s_q.ctl[gpt_pkg::GPT_C_AEN])
      else $error("RTC did not wrap to zero");
   a_edge_stop: assert property (split && hb.cm && !wr |=> !s_q.ctl[gpt_pkg::GPT_C_BEN] &&
      s_q.cnt_b == $past(s_q.ilr_b))
      else $error("edge count did not stop and reload");
   a_capture_val: assert property (split && hb.ce && !wr |=> s_q.cap_b == $past(s_q.cnt_b))
      else $error("captured count wrong");
   a_pwm_quiet: assert property (split && s_q.mode_b[gpt_pkg::GPT_MD_AMS] && s_q.mode_b[1:0] ==
      gpt_pkg::GPT_MR_PER |-> !set_v[gpt_pkg::GPT_I_BTO])
      else $error("PWM raised status");
   a_trig_pulse: assert property (trig_b |-> $past(hb.to) && !$past(trig_b, 2) || $past(s_q.ilr_b) == 16'h0
      && $past(s_q.pr_b) == 8'h0)
      else $error("trigger without timeout");
   a_ilr_next: assert property (wr && paddr == gpt_pkg::GPT_BILR_OFS |=> s_q.cnt_b == $past(pwdata[15:0]))
      else $error("interval write not applied next cycle");
endmodule : gpt_timer

// ==== testbench/test_general_purpose_timer_setup.sv ====
// Self-checking bench for the general-purpose timer, driven over APB.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_general_purpose_timer_setup;
   logic        pclk, presetn, psel, penable, pwrite, ccp_a_in, ccp_b_in, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd, prdata;
   logic        pready, pslverr, pwm_a, pwm_b, trig_a, trig_b, irq;
   int          n_mismatch, n_checks, cyc, n, t0, hi, hi2, k;

   gpt_timer i_gpt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ccp_a_in(ccp_a_in),
      .ccp_b_in(ccp_b_in), .pwm_a(pwm_a), .pwm_b(pwm_b), .trig_a(trig_a), .trig_b(trig_b), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) cyc++;

   // The request is held until pready is seen, and a spare edge follows so no signal is driven twice at once.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 50) begin i++; @(posedge pclk); end
      if (i >= 50) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
   task automatic rdr(input logic [11:0] a); apb(1'b0, a, 32'h0000_0000); endtask : rdr
   // Pins go through a synchroniser, so each level is held well past three cycles.
   task automatic pulse(input int pin);
      if (pin == 0) ccp_a_in <= 1'b1; else ccp_b_in <= 1'b1;
      repeat (6) @(posedge pclk);
      if (pin == 0) ccp_a_in <= 1'b0; else ccp_b_in <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : pulse
   task automatic wait_trig();
      int i;
      i = 0;
      @(posedge pclk);
      while (trig_a !== 1'b1 && i < 200) begin i++; @(posedge pclk); end
   endtask : wait_trig
   task automatic wrap_up();
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      ccp_a_in = 1'b0; ccp_b_in = 1'b0;
      void'($urandom(3958));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdr(gpt_pkg::GPT_AILR_OFS); `CHK(rd, 32'hffff_ffff)
      rdr(gpt_pkg::GPT_BILR_OFS); `CHK(rd, 32'h0000_ffff)
      rdr(gpt_pkg::GPT_CFG_OFS); `CHK(rd, 32'h0000_0000)
      rdr(12'h100); `CHK({err, rd}, {1'b1, 32'h0})
      // Split periodic timer on the first half: trigger spacing is interval plus one.
      n = 5 + ($urandom % 16);
      wr(gpt_pkg::GPT_CFG_OFS, 32'h4);
      wr(gpt_pkg::GPT_AMR_OFS, {30'h0, gpt_pkg::GPT_MR_PER});
      wr(gpt_pkg::GPT_AILR_OFS, n);
      wr(gpt_pkg::GPT_IMR_OFS, 32'h1);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h21);
      wait_trig();
      t0 = cyc;
      wait_trig();
      `CHK(cyc - t0, n + 1)
      `CHK(irq, 1'b1)
      wr(gpt_pkg::GPT_CTL_OFS, 32'h0);
      wr(gpt_pkg::GPT_IMR_OFS, 32'h0);
      `CHK(irq, 1'b0)
      rdr(gpt_pkg::GPT_RIS_OFS); `CHK(rd[0], 1'b1)
      wr(gpt_pkg::GPT_IMR_OFS, 32'h1);
      wr(gpt_pkg::GPT_ICR_OFS, 32'h0);
      rdr(gpt_pkg::GPT_MIS_OFS); `CHK(rd[0], 1'b1)
      wr(gpt_pkg::GPT_ICR_OFS, 32'h1);
      rdr(gpt_pkg::GPT_MIS_OFS); `CHK({irq, rd[0]}, 2'b00)
      // One-shot on the second half stops and drops its own enable.
      wr(gpt_pkg::GPT_BMR_OFS, {30'h0, gpt_pkg::GPT_MR_ONE});
      wr(gpt_pkg::GPT_BILR_OFS, 32'ha);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h2100);
      k = 0;
      repeat (30) begin @(posedge pclk); k += int'(trig_b); end
      `CHK(k, 1)
      rdr(gpt_pkg::GPT_CTL_OFS); `CHK(rd[8], 1'b0)
      rdr(gpt_pkg::GPT_RIS_OFS); `CHK(rd[8], 1'b1)
      wr(gpt_pkg::GPT_ICR_OFS, 32'h70f);
      // Edge count from 10 down to match 6: exactly four edges are counted.
      wr(gpt_pkg::GPT_BMR_OFS, {30'h0, gpt_pkg::GPT_MR_CAP});
      wr(gpt_pkg::GPT_BMAT_OFS, 32'h6);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h100);
      for (k = 0; k < 6; k++) begin
         pulse(1);
         rdr(gpt_pkg::GPT_RIS_OFS); `CHK(rd[9], 1'(k >= 3))
      end
      rdr(gpt_pkg::GPT_CTL_OFS); `CHK(rd[8], 1'b0)
      rdr(gpt_pkg::GPT_BCNT_OFS); `CHK(rd[15:0], 16'h000a)
      // Edge timing on the first half latches the count and keeps running.
      wr(gpt_pkg::GPT_AMR_OFS, 32'h7);
      wr(gpt_pkg::GPT_AILR_OFS, 32'hffff);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h1);
      pulse(0);
      rdr(gpt_pkg::GPT_RIS_OFS); `CHK(rd[2], 1'b1)
      rdr(gpt_pkg::GPT_ACNT_OFS); `CHK(rd[15:0] < 16'hffff, 1'b1)
      wr(gpt_pkg::GPT_CTL_OFS, 32'h0);
      wr(gpt_pkg::GPT_ICR_OFS, 32'h70f);
      // PWM: normal and inverted runs from the same start are exact complements.
      wr(gpt_pkg::GPT_AMR_OFS, 32'ha);
      wr(gpt_pkg::GPT_AILR_OFS, 32'd20);
      wr(gpt_pkg::GPT_AMAT_OFS, 32'd10);
      hi = 0;
      hi2 = 0;
      wr(gpt_pkg::GPT_CTL_OFS, 32'h1);
      repeat (210) begin @(posedge pclk); hi += int'(pwm_a); end
      wr(gpt_pkg::GPT_CTL_OFS, 32'h0);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h41);
      repeat (210) begin @(posedge pclk); hi2 += int'(pwm_a); end
      `CHK(hi + hi2, 210)
      `CHK(hi > 0 && hi < 210, 1'b1)
      rdr(gpt_pkg::GPT_RIS_OFS); `CHK(rd, 32'h0)
      wr(gpt_pkg::GPT_CTL_OFS, 32'h0);
      // RTC counts up to match 3, wraps, and runs on with the flag still set.
      wr(gpt_pkg::GPT_CFG_OFS, 32'h1);
      wr(gpt_pkg::GPT_AMAT_OFS, 32'h3);
      wr(gpt_pkg::GPT_IMR_OFS, 32'h8);
      wr(gpt_pkg::GPT_CTL_OFS, 32'h11);
      repeat (4) pulse(0);
      rdr(gpt_pkg::GPT_RIS_OFS); `CHK({irq, rd[3]}, 2'b11)
      rdr(gpt_pkg::GPT_ACNT_OFS);
      t0 = int'(rd);
      pulse(0);
      rdr(gpt_pkg::GPT_ACNT_OFS); `CHK(rd, 32'(t0 + 1))
      wrap_up();
   end
endmodule : test_general_purpose_timer_setup
